// [sra_pkg.sv]
// Shared constants and types for the script register ALU.
package sra_pkg;
   // ==========================================================================
   // Instruction fields
   localparam int OPC_HI  = 29;
   localparam int OPC_LO  = 27;
   localparam int OPR_HI  = 26;
   localparam int OPR_LO  = 24;
   localparam int USE_ACC = 23;
   localparam int RADR_HI = 22;
   localparam int RADR_LO = 16;
   localparam int IMM_HI  = 15;
   localparam int IMM_LO  = 8;
   localparam int CARRY_SC = 10;
   // ==========================================================================
   // Op codes and operators
   localparam logic [2:0] OPC_SET   = 3'h3;
   localparam logic [2:0] OPC_CLEAR = 3'h4;
   localparam logic [2:0] OPC_FROMA = 3'h5;
   localparam logic [2:0] OPC_TOACC = 3'h6;
   localparam logic [2:0] OPC_RMW   = 3'h7;
   localparam logic [2:0] OPR_MOVE  = 3'h0;
   localparam logic [2:0] OPR_SHL   = 3'h1;
   localparam logic [2:0] OPR_OR    = 3'h2;
   localparam logic [2:0] OPR_XOR   = 3'h3;
   localparam logic [2:0] OPR_AND   = 3'h4;
   localparam logic [2:0] OPR_SHR   = 3'h5;
   localparam logic [2:0] OPR_ADD   = 3'h6;
   localparam logic [2:0] OPR_ADDC  = 3'h7;
   // ==========================================================================
   // Bus register map and reset values
   localparam logic [7:0] ADR_ACC   = 8'h00;
   localparam logic [7:0] ADR_FLAGS = 8'h04;
   localparam logic [7:0] ADR_CTRL  = 8'h08;
   localparam int FLG_CARRY = 0;
   localparam int FLG_BUSY  = 1;
   localparam int CTL_EN    = 0;
   localparam logic [7:0] ACC_RST  = 8'h00;
   localparam logic       CTRL_RST = 1'b1;
   // ==========================================================================
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_EXEC = 2'b10
   } sra_state_t;
endpackage

// [sra_script_register_alu.sv]
// Read/write instruction datapath of the script processor with an AHB-Lite register slave.
// ==========================================================================
module sra_script_register_alu
   import sra_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // Instruction from the fetch unit
   input  wire logic        instrValid,
   input  wire logic [31:0] instrWord,
   output logic             instrReady,
   output logic             execDone,
   // Chip register file, read data one cycle after rfRdEn
   output logic             rfRdEn,
   output logic [6:0]       rfRdAddr,
   input  wire logic [7:0]  rfRdData,
   output logic             rfWrEn,
   output logic [6:0]       rfWrAddr,
   output logic [7:0]       rfWrData,
   // State seen by the branch logic
   output logic [7:0]       accValue,
   output logic             carryFlag,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp
);
   // ==========================================================================
   // Reset synchroniser
   logic rstMeta_r;
   logic rstSync_b;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_r <= 1'b0;
         rstSync_b <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_b <= rstMeta_r;
      end
   end

   // ==========================================================================
   // Declarations
   sra_state_t  state_r;
   logic [31:0] instr_r;
   logic [7:0]  acc_r;
   logic        carry_r;
   logic        ctrlEn_r;
   logic        accept;
   logic [2:0]  opc;
   logic [2:0]  opr;
   logic [7:0]  srcByte;
   logic [7:0]  opnd;
   logic [7:0]  result;
   logic        carryNxt;
   logic [8:0]  sum;
   logic        busWr_r;
   logic [7:0]  busAddr_r;
   logic        addrPhase;

   assign accept = instrValid && instrReady;
   assign opc = instr_r[OPC_HI:OPC_LO];
   assign opr = instr_r[OPR_HI:OPR_LO];

   // ==========================================================================
   // Operand selection and ALU
   always_comb begin
      srcByte = (opc == OPC_FROMA) ? acc_r : rfRdData;
      opnd = instr_r[USE_ACC] ? acc_r : instr_r[IMM_HI:IMM_LO];
      sum = {1'b0, srcByte} + {1'b0, opnd};
      if (opr == OPR_ADDC) begin
         sum = sum + {8'h00, carry_r};
      end
      result = opnd;
      carryNxt = carry_r;
      case (opr)
         OPR_MOVE: result = opnd;
         OPR_SHL: begin
            result = {srcByte[6:0], carry_r};
            carryNxt = srcByte[7];
         end
         OPR_SHR: begin
            result = {carry_r, srcByte[7:1]};
            carryNxt = srcByte[0];
         end
         OPR_OR:  result = srcByte | opnd;
         OPR_XOR: result = srcByte ^ opnd;
         OPR_AND: result = srcByte & opnd;
         OPR_ADD, OPR_ADDC: begin
            result = sum[7:0];
            carryNxt = sum[8];
         end
         default: result = opnd;
      endcase
   end

   // ==========================================================================
   // Sequencer
   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         state_r <= ST_IDLE;
         instr_r <= 32'h0000_0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (accept) begin
                  instr_r <= instrWord;
                  if (instrWord[OPC_HI:OPC_LO] >= OPC_FROMA) begin
                     state_r <= ST_READ;
                  end
               end
            end
            ST_READ: state_r <= ST_EXEC;
            ST_EXEC: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // The fetch unit is held off while busy or while software disables the block.
   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         instrReady <= 1'b0;
      end else begin
         instrReady <= ctrlEn_r && (state_r == ST_IDLE) && !accept;
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         execDone <= 1'b0;
      end else begin
         execDone <= (accept && instrWord[OPC_HI:OPC_LO] < OPC_FROMA) || (state_r == ST_EXEC);
      end
   end

   // ==========================================================================
   // Register file port
   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         rfRdEn   <= 1'b0;
         rfRdAddr <= 7'h00;
      end else begin
         rfRdEn <= accept && (instrWord[OPC_HI:OPC_LO] >= OPC_FROMA);
         if (accept) begin
            // Passed through unswapped whatever the host byte order is.
            rfRdAddr <= instrWord[RADR_HI:RADR_LO];
         end
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         rfWrEn   <= 1'b0;
         rfWrAddr <= 7'h00;
         rfWrData <= 8'h00;
      end else begin
         rfWrEn <= (state_r == ST_EXEC) && (opc != OPC_TOACC);
         if (state_r == ST_EXEC) begin
            rfWrAddr <= instr_r[RADR_HI:RADR_LO];
            rfWrData <= result;
         end
      end
   end

   // ==========================================================================
   // Accumulator and carry; the instruction path wins over a bus write.
   assign addrPhase = hsel && hready && htrans[1];

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         acc_r <= ACC_RST;
      end else if (state_r == ST_EXEC && opc == OPC_TOACC) begin
         acc_r <= result;
      end else if (busWr_r && busAddr_r == ADR_ACC) begin
         acc_r <= hwdata[7:0];
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         carry_r <= 1'b0;
      end else if (state_r == ST_EXEC) begin
         carry_r <= carryNxt;
      end else if (accept && instrWord[CARRY_SC] && instrWord[OPC_HI:OPC_LO] == OPC_SET) begin
         carry_r <= 1'b1;
      end else if (accept && instrWord[CARRY_SC] && instrWord[OPC_HI:OPC_LO] == OPC_CLEAR) begin
         carry_r <= 1'b0;
      end else if (busWr_r && busAddr_r == ADR_FLAGS) begin
         carry_r <= hwdata[FLG_CARRY];
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         ctrlEn_r <= CTRL_RST;
      end else if (busWr_r && busAddr_r == ADR_CTRL) begin
         ctrlEn_r <= hwdata[CTL_EN];
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         accValue  <= ACC_RST;
         carryFlag <= 1'b0;
      end else begin
         accValue  <= acc_r;
         carryFlag <= carry_r;
      end
   end

   // ==========================================================================
   // AHB-Lite slave: zero wait states, always OKAY, unmapped reads as zero.
   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         busWr_r   <= 1'b0;
         busAddr_r <= 8'h00;
      end else begin
         busWr_r <= addrPhase && hwrite;
         if (addrPhase) begin
            busAddr_r <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         hrdata <= 32'h0000_0000;
      end else if (addrPhase && !hwrite) begin
         hrdata <= 32'h0000_0000;
         case (haddr[7:0])
            ADR_ACC:   hrdata[7:0] <= acc_r;
            ADR_FLAGS: begin
               hrdata[FLG_CARRY] <= carry_r;
               hrdata[FLG_BUSY]  <= (state_r != ST_IDLE);
            end
            ADR_CTRL:  hrdata[CTL_EN] <= ctrlEn_r;
            default:   hrdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstSync_b);

   logic exec;
   assign exec = (state_r == ST_EXEC);

   io_noread_a: assert property (accept && instrWord[OPC_HI:OPC_LO] < OPC_FROMA |=> !rfRdEn ##1 !rfWrEn)
      else $error("I/O instruction touched the register file");
   rw_read_a: assert property (accept && instrWord[OPC_HI:OPC_LO] >= OPC_FROMA
      |=> rfRdEn && rfRdAddr == $past(instrWord[RADR_HI:RADR_LO]) ##2 execDone)
      else $error("Register read or completion missing");
   rmw_back_a: assert property (exec && opc == OPC_RMW |=> rfWrEn && rfWrAddr == rfRdAddr)
      else $error("Read-modify-write did not write the same register");
   to_acc_a: assert property (exec && opc == OPC_TOACC |=> !rfWrEn && acc_r == $past(result))
      else $error("Move to accumulator wrong");
   from_acc_a: assert property (exec && opc == OPC_FROMA && opr == OPR_OR && !instr_r[USE_ACC]
      |=> rfWrEn && rfWrData == ($past(acc_r) | $past(instr_r[IMM_HI:IMM_LO])))
      else $error("Move from accumulator wrong");
   move_imm_a: assert property (exec && opr == OPR_MOVE && !instr_r[USE_ACC] && opc != OPC_TOACC
      |=> rfWrData == $past(instr_r[IMM_HI:IMM_LO]))
      else $error("Move did not pass the immediate byte");
   shl_carry_a: assert property (exec && opr == OPR_SHL
      |=> carry_r == $past(srcByte[7])
          && (rfWrEn ? rfWrData : acc_r) == {$past(srcByte[6:0]), $past(carry_r)})
      else $error("Left shift carry wrong");
   shr_data_a: assert property (exec && opr == OPR_SHR && opc == OPC_RMW
      |=> rfWrData == {$past(carry_r), $past(rfRdData[7:1])})
      else $error("Right shift result wrong");
   add_carry_a: assert property (exec && opr == OPR_ADDC && opc == OPC_RMW && !instr_r[USE_ACC]
      |=> {carry_r, rfWrData} == 9'($past(rfRdData)) + 9'($past(instr_r[IMM_HI:IMM_LO])) + 9'($past(carry_r)))
      else $error("Add with carry wrong");
   carry_sc_a: assert property (accept && instrWord[CARRY_SC] && instrWord[OPC_HI:OPC_LO] == OPC_SET
      |=> carry_r ##1 carryFlag)
      else $error("Set carry failed");

   rmw_c: cover property (exec && opc == OPC_RMW && opr == OPR_ADDC);
   toacc_c: cover property (exec && opc == OPC_TOACC && instr_r[USE_ACC]);
   froma_c: cover property (exec && opc == OPC_FROMA && opr == OPR_SHR);
   clrc_c: cover property (accept && instrWord[CARRY_SC] && instrWord[OPC_HI:OPC_LO] == OPC_CLEAR);
endmodule // sra_script_register_alu

// [sra_regfile_model.sv]
// Behavioural chip register file answering the datapath's read and write strobes.
module sra_regfile_model (
   // Clock
   input  wire logic       mclk,
   // Read side
   input  wire logic       rfRdEn,
   input  wire logic [6:0] rfRdAddr,
   output logic      [7:0] rfRdData,
   // Write side
   input  wire logic       rfWrEn,
   input  wire logic [6:0] rfWrAddr,
   input  wire logic [7:0] rfWrData
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] mem [0:127];
   logic       held;

   // ====================
   // Read and write port
   // Read data stands for one cycle only; afterwards it is inverted so a late sample is caught.
   always @(posedge mclk) begin
      held <= rfRdEn;
      if (rfRdEn) begin
         rfRdData <= mem[rfRdAddr];
      end else if (held) begin
         rfRdData <= ~rfRdData;
      end
      if (rfWrEn) begin
         mem[rfWrAddr] <= rfWrData;
      end
   end
endmodule // sra_regfile_model

// [testbench.sv]
// Self-checking bench for the script register ALU: bus registers, I/O codes, operation table.
module testbench
   import sra_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        mclk, rst_b, instrValid, instrReady, execDone, rfRdEn, rfWrEn, carryFlag;
   logic        hsel, hwrite, hreadyout, hresp;
   logic [31:0] instrWord, haddr, hwdata, hrdata;
   logic [6:0]  rfRdAddr, rfWrAddr;
   logic [7:0]  rfRdData, rfWrData, accValue;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          nErrors, checked;

   sra_script_register_alu sra_script_register_alu_i (.mclk(mclk), .rst_b(rst_b), .instrValid(instrValid),
      .instrWord(instrWord), .instrReady(instrReady), .execDone(execDone), .rfRdEn(rfRdEn), .rfRdAddr(rfRdAddr),
      .rfRdData(rfRdData), .rfWrEn(rfWrEn), .rfWrAddr(rfWrAddr), .rfWrData(rfWrData), .accValue(accValue),
      .carryFlag(carryFlag), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

   sra_regfile_model sra_regfile_model_i (.mclk(mclk), .rfRdEn(rfRdEn), .rfRdAddr(rfRdAddr), .rfRdData(rfRdData),
      .rfWrEn(rfWrEn), .rfWrAddr(rfWrAddr), .rfWrData(rfWrData));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // ====================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         nErrors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("errors=%0d checks=%0d", nErrors, checked);
      if (nErrors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Waits on instrReady (0), execDone (1) or hready (2); a wait that runs out ends the run.
   task automatic waitOn(input int sel);
      for (int i = 0; i < 20; i++) begin
         @(posedge mclk);
         if ((sel == 0 ? instrReady : sel == 1 ? execDone : hreadyout) === 1'b1) return;
      end
      nErrors++;
      results();
   endtask

   task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h000000, adr};
      waitOn(2);
      htrans <= 2'h0;
      hwdata <= wd;
      waitOn(2);
      rd = hrdata;
      check(hresp, 1'b0);
   endtask

   task automatic offer(input logic [31:0] w);
      @(posedge mclk);
      instrValid <= 1'b1;
      instrWord <= w;
   endtask

   // Two spare edges let the delayed accumulator and carry copies settle.
   task automatic complete();
      waitOn(0);
      instrValid <= 1'b0;
      waitOn(1);
      repeat (2) @(posedge mclk);
   endtask

   task automatic exec(input logic [31:0] w);
      offer(w);
      complete();
   endtask

   function automatic logic [8:0] alu(input logic [2:0] opr, input logic [7:0] s, input logic [7:0] d,
                                      input logic c);
      case (opr)
         OPR_MOVE: alu = {c, d};
         OPR_SHL:  alu = {s, c};
         OPR_SHR:  alu = {s[0], c, s[7:1]};
         OPR_OR:   alu = {c, s | d};
         OPR_XOR:  alu = {c, s ^ d};
         OPR_AND:  alu = {c, s & d};
         OPR_ADD:  alu = {1'b0, s} + {1'b0, d};
         default:  alu = {1'b0, s} + {1'b0, d} + {8'h00, c};
      endcase
   endfunction

   // ====================
   // Scenarios
   task automatic regsReset();
      logic [31:0] rd;
      bus(1'b0, ADR_ACC, 32'h00000000, rd);
      check(rd, {24'h000000, ACC_RST});
      bus(1'b0, ADR_CTRL, 32'h00000000, rd);
      check(rd, {31'h00000000, CTRL_RST});
      bus(1'b0, ADR_FLAGS, 32'h00000000, rd);
      check(rd, 32'h00000000);
      bus(1'b1, 8'h0C, 32'hFFFFFFFF, rd);
      bus(1'b0, 8'h0C, 32'h00000000, rd);
      check(rd, 32'h00000000);
   endtask

   task automatic ioOps();
      logic [31:0] rd;
      for (int opc = 0; opc < 5; opc++) begin
         sra_regfile_model_i.mem[7'h11] = 8'h5A;
         bus(1'b1, ADR_ACC, 32'h0000003C, rd);
         bus(1'b1, ADR_FLAGS, {31'h00000000, opc != 3}, rd);
         exec({2'b01, 3'(opc), OPR_ADD, 1'b1, 7'h11, 8'h24, 8'h00});
         check(carryFlag, opc != 4);
         check(accValue, 8'h3C);
         check(sra_regfile_model_i.mem[7'h11], 8'h5A);
      end
   endtask

   task automatic tableOps();
      logic [31:0] rd;
      logic [8:0]  r;
      logic [7:0]  acc, regv, imm, s;
      logic [6:0]  a;
      logic        c;
      for (int opc = 5; opc < 8; opc++) begin
         for (int k = 0; k < 16; k++) begin
            a = 7'(k * 9 + opc * 41);
            acc = 8'(8'hB4 + k * 37);
            regv = 8'(8'h96 - k * 23);
            imm = 8'(8'hE7 + k * 11);
            c = k[0] ^ opc[0];
            sra_regfile_model_i.mem[a] = regv;
            bus(1'b1, ADR_ACC, {24'h000000, acc}, rd);
            bus(1'b1, ADR_FLAGS, {31'h00000000, c}, rd);
            s = (opc == 5) ? acc : regv;
            r = alu(3'(k >> 1), s, k[0] ? acc : imm, c);
            exec({2'b01, 3'(opc), 3'(k >> 1), k[0], a, imm, 8'hA5});
            check(accValue, (opc == 6) ? r[7:0] : acc);
            check(sra_regfile_model_i.mem[a], (opc == 6) ? regv : r[7:0]);
            check(carryFlag, r[8]);
         end
      end
   endtask

   // Difference of two registers by inverting, incrementing and adding.
   task automatic subtract();
      logic [31:0] rd;
      sra_regfile_model_i.mem[7'h20] = 8'h50;
      bus(1'b1, ADR_ACC, 32'h00000013, rd);
      exec({2'b01, OPC_FROMA, OPR_XOR, 1'b0, 7'h21, 8'hFF, 8'h00});
      exec({2'b01, OPC_RMW, OPR_ADD, 1'b0, 7'h21, 8'h01, 8'h00});
      exec({2'b01, OPC_TOACC, OPR_OR, 1'b0, 7'h21, 8'h00, 8'h00});
      exec({2'b01, OPC_RMW, OPR_ADD, 1'b1, 7'h20, 8'h00, 8'h00});
      check(sra_regfile_model_i.mem[7'h20], 8'h3D);
   endtask

   // With the enable bit cleared an offered instruction must wait.
   task automatic refuse();
      logic [31:0] rd;
      bus(1'b1, ADR_FLAGS, 32'h00000000, rd);
      bus(1'b1, ADR_CTRL, 32'h00000000, rd);
      repeat (2) @(posedge mclk);
      offer({2'b01, OPC_SET, 3'h0, 24'h000400});
      repeat (4) begin
         @(posedge mclk);
         check(instrReady, 1'b0);
      end
      bus(1'b1, ADR_CTRL, 32'h00000001, rd);
      complete();
      check(carryFlag, 1'b1);
   endtask

   initial begin
      nErrors = 0;
      checked = 0;
      rst_b = 1'b0;
      instrValid = 1'b0;
      instrWord = 32'h00000000;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      regsReset();
      ioOps();
      tableOps();
      subtract();
      refuse();
      results();
   end
endmodule // testbench
